// >>> verilog/fnu_normalize.sv
`timescale 1ns/100ps
module fnu_normalize
    import fnu_pkg::*;
(
    // Clock, reset, enable
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic ce_i,
    // Instruction issue
    input wire logic issue_i,
    input wire logic [fnu_pkg::INSTR_W-1:0] instr_i,
    input wire logic [fnu_pkg::WORD_W-1:0] operand_i,
    // Result to register files
    output logic result_valid_o,
    output logic [fnu_pkg::WORD_W-1:0] result_o,
    output logic [fnu_pkg::DEST_W-1:0] result_dest_o,
    output logic sign_o,
    output logic underflow_o,
    output logic [fnu_pkg::INDEX_W-1:0] index_o,
    output logic [fnu_pkg::DEST_W-1:0] index_dest_o,
    output logic indefinite_o,
    output logic infinite_o,
    // Avalon-MM slave
    input wire logic [fnu_pkg::BUS_AW-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [fnu_pkg::BUS_DW-1:0] avs_writedata_i,
    output logic [fnu_pkg::BUS_DW-1:0] avs_readdata_o,
    output logic avs_waitrequest_o
);
    import fnu_pkg::*;

    localparam int CX_W = COEF_W + 1;

    // ==========================================================
    // State
    typedef struct packed {
        fnu_bus_e bus_state;
        logic [BUS_DW-1:0] readdata;
        logic unit_en;
        logic [WORD_W-1:0] sw_operand;
        logic [INSTR_W-1:0] sw_instr;
        logic sw_pend;
        logic st_done;
        // Issue period
        logic s1_go;
        logic s1_round;
        logic [WORD_W-1:0] s1_op;
        logic [DEST_W-1:0] s1_xdest;
        logic [DEST_W-1:0] s1_bdest;
        // Second period
        logic s2_go;
        logic s2_sign;
        logic s2_en;
        logic s2_exp10;
        logic s2_zero24;
        logic [CNT_W-1:0] s2_cnt;
        logic [CX_W-1:0] s2_coef;
        logic [1:0] s2_sel2;
        logic [3:0] s2_sel4;
        logic [3:0] s2_sel16;
        logic [EXP_W-EXP_LO_W-1:0] s2_exp_hi;
        logic [EXP_LO_W-1:0] s2_diff_lo;
        logic s2_borrow;
        logic [DEST_W-1:0] s2_xdest;
        logic [DEST_W-1:0] s2_bdest;
        // Third period, delivered
        logic out_valid;
        logic [WORD_W-1:0] out_word;
        logic out_sign;
        logic out_unf;
        logic [INDEX_W-1:0] out_index;
        logic out_indef;
        logic out_inf;
        logic [DEST_W-1:0] out_xdest;
        logic [DEST_W-1:0] out_bdest;
    } fnu_state_s;

    fnu_state_s st_r;
    fnu_state_s st_nxt;

    // ==========================================================
    // Decoding shared by issue paths and shift controls
    function automatic logic is_normalize(input logic [INSTR_W-1:0] w);
        return (w[F_LSB+:3] == NORM_F) && (w[M_LSB+1+:2] == NORM_M_HI);
    endfunction

    function automatic logic [3:0] onehot4(input logic [1:0] v);
        return 4'h1 << v;
    endfunction

    // ==========================================================
    // Second period datapath
    logic [WORD_W-1:0] op_raw;
    logic op_sign;
    logic [EXP_W-1:0] exp_pos;
    logic [COEF_W-1:0] coef_pos;
    logic shift_en;
    logic [CNT_W-1:0] lz_cnt;
    logic [CNT_W-1:0] cnt_g;
    logic [CX_W-1:0] coef_rnd;
    logic [CX_W-1:0] rank1;

    assign op_raw = st_r.s1_op;
    assign op_sign = op_raw[SIGN_BIT];
    // Exponent to biased positive form
    assign exp_pos = op_raw[EXP_MSB:EXP_LSB] ^ {EXP_W{op_sign}};
    // Coefficient to positive form
    assign coef_pos = op_raw[COEF_W-1:0] ^ {COEF_W{op_sign}};
    // Overflow or indefinite exponent stops all shifting
    assign shift_en = ~&exp_pos[ONES_CHECK_W-1:0];

    fnu_lead_zero #(
        .W(COEF_W),
        .CW(CNT_W)
    ) u_lead_zero (
        .coef_i(coef_pos),
        .count_o(lz_cnt)
    );

    assign cnt_g = shift_en ? lz_cnt : '0;
    // Round bit rides one place below bit 0
    assign coef_rnd = {coef_pos, st_r.s1_round};
    assign rank1 = (lz_cnt[0] && shift_en) ? (coef_rnd << 1) : coef_rnd;

    // ==========================================================
    // Third period datapath
    logic [CX_W-1:0] rank2;
    logic [CX_W-1:0] rank3;
    logic [CX_W-1:0] rank4;
    logic [EXP_W-EXP_LO_W:0] exp_hi_diff;
    logic [EXP_W-1:0] exp_res;
    logic blocked;
    logic gate_out;

    fnu_shift_rank #(
        .W(CX_W),
        .N(2),
        .STEP(2)
    ) u_rank2 (
        .data_i(st_r.s2_coef),
        .sel_i(st_r.s2_sel2),
        .data_o(rank2)
    );

    fnu_shift_rank #(
        .W(CX_W),
        .N(4),
        .STEP(4)
    ) u_rank3 (
        .data_i(rank2),
        .sel_i(st_r.s2_sel4),
        .data_o(rank3)
    );

    fnu_shift_rank #(
        .W(CX_W),
        .N(4),
        .STEP(16)
    ) u_rank4 (
        .data_i(rank3),
        .sel_i(st_r.s2_sel16),
        .data_o(rank4)
    );

    // Second adder stage takes the registered borrow
    assign exp_hi_diff = {1'b0, st_r.s2_exp_hi}
        - {{(EXP_W - EXP_LO_W){1'b0}}, st_r.s2_borrow};
    assign exp_res = {exp_hi_diff[EXP_W-EXP_LO_W-1:0], st_r.s2_diff_lo};
    // Borrow out of bit 10 means below the exponent range
    assign blocked = st_r.s2_zero24 || exp_hi_diff[EXP_W-EXP_LO_W];
    assign gate_out = st_r.s2_go && !blocked;

    // ==========================================================
    // Bus decode
    logic bus_req;
    logic bus_take;
    logic [BUS_DW-1:0] status_word;

    assign bus_req = avs_read_i || avs_write_i;
    assign bus_take = bus_req && (st_r.bus_state == BUS_ACK);
    assign avs_waitrequest_o = bus_req && (st_r.bus_state != BUS_ACK);
    assign avs_readdata_o = st_r.readdata;

    always_comb begin
        status_word = '0;
        status_word[ST_INDEF] = st_r.out_indef;
        status_word[ST_INF] = st_r.out_inf;
        status_word[ST_UNF] = st_r.out_unf;
        status_word[ST_SIGN] = st_r.out_sign;
        status_word[ST_DONE] = st_r.st_done;
        status_word[ST_PEND] = st_r.sw_pend;
    end

    function automatic logic [BUS_DW-1:0] read_mux(
        input logic [BUS_AW-1:0] a,
        input fnu_state_s s,
        input logic [BUS_DW-1:0] stat
    );
        logic [BUS_DW-1:0] d;
        d = '0;
        case (a)
            REG_CTRL: d[0] = s.unit_en;
            REG_OPND_LO: d = s.sw_operand[BUS_DW-1:0];
            REG_OPND_HI: d[WORD_W-BUS_DW-1:0] = s.sw_operand[WORD_W-1:BUS_DW];
            REG_INSTR: d[INSTR_W-1:0] = s.sw_instr;
            REG_ISSUE: d[0] = s.sw_pend;
            REG_RES_LO: d = s.out_word[BUS_DW-1:0];
            REG_RES_HI: d[WORD_W-BUS_DW-1:0] = s.out_word[WORD_W-1:BUS_DW];
            REG_INDEX: d[INDEX_W-1:0] = s.out_index;
            REG_STATUS: d = stat;
            default: d = '0;
        endcase
        return d;
    endfunction

    // ==========================================================
    // Next state
    logic cpu_go;
    logic sw_go;
    logic [INSTR_W-1:0] iss_instr;
    logic [WORD_W-1:0] iss_op;

    // Processor issue wins; a software issue waits for a free cycle
    assign sw_go = st_r.sw_pend && !issue_i && st_r.unit_en;
    assign cpu_go = issue_i && st_r.unit_en;
    assign iss_instr = issue_i ? instr_i : st_r.sw_instr;
    assign iss_op = issue_i ? operand_i : st_r.sw_operand;

    always_comb begin
        st_nxt = st_r;

        // Bus slave: read data latched on entry, write acts on exit
        case (st_r.bus_state)
            BUS_IDLE: begin
                if (bus_req) begin
                    st_nxt.bus_state = BUS_ACK;
                    st_nxt.readdata = read_mux(avs_address_i, st_r,
                        status_word);
                end
            end
            BUS_ACK: begin
                st_nxt.bus_state = BUS_IDLE;
            end
            default: st_nxt.bus_state = BUS_IDLE;
        endcase

        if (sw_go) begin
            st_nxt.sw_pend = 1'b0;
        end
        if (bus_take && avs_write_i) begin
            case (avs_address_i)
                REG_CTRL: st_nxt.unit_en = avs_writedata_i[0];
                REG_OPND_LO:
                    st_nxt.sw_operand[BUS_DW-1:0] = avs_writedata_i;
                REG_OPND_HI:
                    st_nxt.sw_operand[WORD_W-1:BUS_DW] =
                        avs_writedata_i[WORD_W-BUS_DW-1:0];
                REG_INSTR:
                    st_nxt.sw_instr = avs_writedata_i[INSTR_W-1:0];
                REG_ISSUE: begin
                    if (avs_writedata_i[0]) begin
                        st_nxt.sw_pend = 1'b1;
                    end
                end
                REG_STATUS: begin
                    if (avs_writedata_i[ST_DONE]) begin
                        st_nxt.st_done = 1'b0;
                    end
                end
                default: st_nxt.unit_en = st_r.unit_en;
            endcase
        end

        // Issue period: capture operand and designators
        st_nxt.s1_go = (cpu_go || sw_go) && is_normalize(iss_instr);
        st_nxt.s1_round = iss_instr[M_LSB];
        st_nxt.s1_op = iss_op;
        st_nxt.s1_xdest = iss_instr[I_LSB+:DEST_W];
        st_nxt.s1_bdest = iss_instr[J_LSB+:DEST_W];

        // Second period
        st_nxt.s2_go = st_r.s1_go;
        st_nxt.s2_sign = op_sign;
        st_nxt.s2_en = shift_en;
        st_nxt.s2_exp10 = exp_pos[EXP_W-1];
        st_nxt.s2_zero24 = (lz_cnt == ZERO_COEF_COUNT) && shift_en
            && !st_r.s1_round;
        st_nxt.s2_cnt = cnt_g;
        st_nxt.s2_coef = rank1;
        st_nxt.s2_sel2 = {cnt_g[1], ~cnt_g[1]};
        st_nxt.s2_sel4 = onehot4(cnt_g[3:2]);
        st_nxt.s2_sel16 = onehot4(cnt_g[5:4]);
        st_nxt.s2_exp_hi = exp_pos[EXP_W-1:EXP_LO_W];
        {st_nxt.s2_borrow, st_nxt.s2_diff_lo} =
            {1'b0, exp_pos[EXP_LO_W-1:0]} - {1'b0, cnt_g};
        st_nxt.s2_xdest = st_r.s1_xdest;
        st_nxt.s2_bdest = st_r.s1_bdest;

        // Third period: results and flags to the destinations
        st_nxt.out_valid = st_r.s2_go;
        st_nxt.out_xdest = st_r.s2_xdest;
        st_nxt.out_bdest = st_r.s2_bdest;
        st_nxt.out_sign = st_r.s2_sign;
        st_nxt.out_word = gate_out
            ? ~{1'b0, exp_res, rank4[CX_W-1:1]}
            : '1;
        st_nxt.out_unf = st_r.s2_go && blocked;
        // Upper index bits are always zero under go-normalize
        st_nxt.out_index = st_r.s2_go
            ? {{(INDEX_W - CNT_W){1'b0}}, st_r.s2_cnt}
            : '0;
        st_nxt.out_indef = st_r.s2_go && !st_r.s2_en
            && !st_r.s2_exp10;
        st_nxt.out_inf = st_r.s2_go && !st_r.s2_en
            && st_r.s2_exp10;
        // A result landing on a clear write still sets done
        if (st_r.s2_go) begin
            st_nxt.st_done = 1'b1;
        end
    end

    // ==========================================================
    // Registers
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            st_r <= '0;
            st_r.unit_en <= CTRL_EN_RESET;
        end else if (ce_i) begin
            st_r <= st_nxt;
        end
    end

    // ==========================================================
    // Outputs
    assign result_valid_o = st_r.out_valid;
    assign result_o = st_r.out_word;
    assign result_dest_o = st_r.out_xdest;
    assign sign_o = st_r.out_sign;
    assign underflow_o = st_r.out_unf;
    assign index_o = st_r.out_index;
    assign index_dest_o = st_r.out_bdest;
    assign indefinite_o = st_r.out_indef;
    assign infinite_o = st_r.out_inf;

endmodule

// >>> verilog/fnu_pkg.sv
package fnu_pkg;

    // ==========================================================
    // Widths
    localparam int WORD_W = 60;
    localparam int COEF_W = 48;
    localparam int EXP_W = 11;
    localparam int CNT_W = 6;
    localparam int INDEX_W = 18;
    localparam int INSTR_W = 15;
    localparam int DEST_W = 3;
    localparam int BUS_AW = 6;
    localparam int BUS_DW = 32;

    // ==========================================================
    // Word layout
    localparam int SIGN_BIT = 59;
    localparam int EXP_LSB = 48;
    localparam int EXP_MSB = 58;
    localparam int ONES_CHECK_W = 10;
    localparam int EXP_LO_W = 6;

    // ==========================================================
    // Instruction word fields and normalize opcodes 24 and 25
    localparam int F_LSB = 12;
    localparam int M_LSB = 9;
    localparam int I_LSB = 6;
    localparam int J_LSB = 3;
    localparam logic [2:0] NORM_F = 3'h2;
    localparam logic [1:0] NORM_M_HI = 2'h2;
    localparam logic [CNT_W-1:0] ZERO_COEF_COUNT = 6'h30;

    // ==========================================================
    // Register byte offsets
    localparam logic [BUS_AW-1:0] REG_CTRL = 6'h00;
    localparam logic [BUS_AW-1:0] REG_OPND_LO = 6'h04;
    localparam logic [BUS_AW-1:0] REG_OPND_HI = 6'h08;
    localparam logic [BUS_AW-1:0] REG_INSTR = 6'h0C;
    localparam logic [BUS_AW-1:0] REG_ISSUE = 6'h10;
    localparam logic [BUS_AW-1:0] REG_RES_LO = 6'h14;
    localparam logic [BUS_AW-1:0] REG_RES_HI = 6'h18;
    localparam logic [BUS_AW-1:0] REG_INDEX = 6'h1C;
    localparam logic [BUS_AW-1:0] REG_STATUS = 6'h20;

    // ==========================================================
    // Status bit positions and reset values
    localparam int ST_INDEF = 0;
    localparam int ST_INF = 1;
    localparam int ST_UNF = 2;
    localparam int ST_SIGN = 3;
    localparam int ST_DONE = 4;
    localparam int ST_PEND = 5;
    localparam logic CTRL_EN_RESET = 1'b1;

    typedef enum logic [0:0] {
        BUS_IDLE = 1'b0,
        BUS_ACK = 1'b1
    } fnu_bus_e;

endpackage

// >>> verilog/fnu_lead_zero.sv
`timescale 1ns/100ps
module fnu_lead_zero #(
    parameter int W = 48,
    parameter int CW = 6
) (
    // Data in
    input wire logic [W-1:0] coef_i,
    // Count out
    output logic [CW-1:0] count_o
);
    if ((1 << CW) <= W) begin : g_bad_width
        $error("fnu_lead_zero: count too narrow");
    end

    // All-zero input gives W
    function automatic logic [CW-1:0] lead_zeros(input logic [W-1:0] d);
        logic [CW-1:0] n;
        logic found;
        n = CW'(W);
        found = 1'b0;
        for (int i = W - 1; i >= 0; i--) begin
            if (d[i] && !found) begin
                n = CW'(W - 1 - i);
                found = 1'b1;
            end
        end
        return n;
    endfunction

    always_comb begin
        count_o = lead_zeros(coef_i);
    end

endmodule

// >>> verilog/fnu_shift_rank.sv
`timescale 1ns/100ps
module fnu_shift_rank #(
    parameter int W = 49,
    parameter int N = 4,
    parameter int STEP = 4
) (
    // Data and one-hot select
    input wire logic [W-1:0] data_i,
    input wire logic [N-1:0] sel_i,
    // Shifted data
    output logic [W-1:0] data_o
);
    if (N < 2 || STEP < 1 || (N - 1) * STEP >= W) begin : g_bad_rank
        $error("fnu_shift_rank: unsupported shape");
    end

    logic [W-1:0] term [N];

    // No select set gives zeros, as the gated rank would
    for (genvar g = 0; g < N; g++) begin : g_term
        assign term[g] = sel_i[g] ? (data_i << (g * STEP)) : '0;
    end

    always_comb begin
        data_o = '0;
        for (int i = 0; i < N; i++) begin
            data_o = data_o | term[i];
        end
    end

endmodule

// >>> testbench/fnu_normalize_properties.sv
`timescale 1ns/100ps
// ==========
// Port checker for the normalize unit
module fnu_normalize_chk
    import fnu_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_i,
    // Issue
    input wire logic issue_i,
    input wire logic [fnu_pkg::INSTR_W-1:0] instr_i,
    input wire logic [fnu_pkg::WORD_W-1:0] operand_i,
    // Result
    input wire logic result_valid_o,
    input wire logic [fnu_pkg::WORD_W-1:0] result_o,
    input wire logic [fnu_pkg::DEST_W-1:0] result_dest_o,
    input wire logic sign_o,
    input wire logic underflow_o,
    input wire logic [fnu_pkg::INDEX_W-1:0] index_o,
    input wire logic [fnu_pkg::DEST_W-1:0] index_dest_o,
    input wire logic indefinite_o,
    input wire logic infinite_o,
    // Register bus
    input wire logic [fnu_pkg::BUS_AW-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [fnu_pkg::BUS_DW-1:0] avs_writedata_i,
    input wire logic avs_waitrequest_o
);
    logic en_r;
    logic norm_w;
    logic sgn_w;
    logic ehi_w;
    logic [5:0] dst_w;
    assign norm_w = instr_i[14:12] == NORM_F && instr_i[11:10] == NORM_M_HI;
    assign sgn_w = operand_i[SIGN_BIT];
    assign ehi_w = operand_i[EXP_MSB] ^ operand_i[SIGN_BIT];
    assign dst_w = instr_i[8:3];
    // Enable bit mirrored from bus writes so refused issues are skipped
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            en_r <= CTRL_EN_RESET;
        end else if (avs_write_i && !avs_waitrequest_o
                     && avs_address_i == REG_CTRL) begin
            en_r <= avs_writedata_i[0];
        end
    end
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);
    chk_issue_latency: assert property (issue_i && norm_w && en_r |-> ##3 result_valid_o)
        else $error("no result three edges after issue");
    chk_valid_cause: assert property (result_valid_o |-> $past(issue_i, 3) && $past(norm_w, 3))
        else $error("result without a normalize issue");
    chk_flag_pulse: assert property ((indefinite_o || infinite_o) |-> result_valid_o && !(indefinite_o && infinite_o))
        else $error("special flag outside result slot");
    chk_index_high: assert property (result_valid_o |-> index_o[17:6] == 12'h000)
        else $error("index upper bits not zero");
    chk_blocked_ones: assert property (result_valid_o && underflow_o |-> &result_o && index_o[5:0] != 6'h00)
        else $error("blocked word not all ones");
    chk_special_zero: assert property (result_valid_o && (indefinite_o || infinite_o) |-> index_o[5:0] == 6'h00 && !underflow_o)
        else $error("special operand gave a count");
    chk_special_kind: assert property (result_valid_o && (indefinite_o || infinite_o) |-> infinite_o == $past(ehi_w, 3))
        else $error("indefinite and infinite swapped");
    chk_sign_fwd: assert property (result_valid_o |-> sign_o == $past(sgn_w, 3))
        else $error("forwarded sign wrong");
    chk_dest_pipe: assert property (result_valid_o |-> {result_dest_o, index_dest_o} == $past(dst_w, 3))
        else $error("destinations not pipelined");
    chk_norm_top: assert property (result_valid_o && !underflow_o && !indefinite_o && !infinite_o |-> !result_o[47])
        else $error("coefficient not normalized");
    chk_bus_wait: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
        else $error("bus wait longer than one cycle");
endmodule

bind fnu_normalize fnu_normalize_chk chk_u (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .issue_i(issue_i),
    .instr_i(instr_i), .operand_i(operand_i),
    .result_valid_o(result_valid_o), .result_o(result_o),
    .result_dest_o(result_dest_o), .sign_o(sign_o),
    .underflow_o(underflow_o), .index_o(index_o),
    .index_dest_o(index_dest_o), .indefinite_o(indefinite_o),
    .infinite_o(infinite_o), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i),
    .avs_waitrequest_o(avs_waitrequest_o)
);

// >>> testbench/fnu_dest_model.sv
`timescale 1ns/100ps
// ==========
// Destination register input control
module fnu_dest_model
    import fnu_pkg::*;
(
    // From the unit
    input wire logic [fnu_pkg::WORD_W-1:0] result_i,
    input wire logic sign_i,
    input wire logic underflow_i,
    // Value entering the destination
    output logic [fnu_pkg::WORD_W-1:0] dest_word_o
);
    // Underflow turns the word of ones into zeros
    always_comb begin
        if (underflow_i) begin
            dest_word_o = ~result_i;
        end else if (!sign_i) begin
            dest_word_o = ~result_i;
        end else begin
            dest_word_o = result_i;
        end
    end
endmodule

// >>> testbench/testbench.sv
`timescale 1ns/100ps
module testbench;
    import fnu_pkg::*;
    typedef struct packed {
        logic [59:0] r;
        logic [17:0] x;
        logic [2:0] f;
        logic [5:0] d;
        logic s;
        logic [59:0] w;
    } fnu_tb_exp_s;
    logic clk_sys_i, reset_i, issue_i, en;
    logic [INSTR_W-1:0] instr_i;
    logic [WORD_W-1:0] operand_i, result_o, dest_word, op;
    logic result_valid_o, sign_o, underflow_o, indefinite_o, infinite_o;
    logic [DEST_W-1:0] result_dest_o, index_dest_o;
    logic [INDEX_W-1:0] index_o;
    logic [BUS_AW-1:0] avs_address_i;
    logic avs_read_i, avs_write_i, avs_waitrequest_o;
    logic [BUS_DW-1:0] avs_writedata_i, avs_readdata_o, rd, seed, w;
    int bad_count, comparisons;
    fnu_tb_exp_s exp_q[$];
    logic [WORD_W-1:0] corner [7] = '{60'h400000000000000,
        60'h7FF123456789ABC, 60'h3FF000000000001, 60'hBFFFFFFFFFF0000,
        60'h001000000000001, 60'h555800000000000, 60'h800000000000000};

    fnu_normalize dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
        .ce_i(1'b1), .issue_i(issue_i), .instr_i(instr_i),
        .operand_i(operand_i), .result_valid_o(result_valid_o),
        .result_o(result_o), .result_dest_o(result_dest_o),
        .sign_o(sign_o), .underflow_o(underflow_o), .index_o(index_o),
        .index_dest_o(index_dest_o), .indefinite_o(indefinite_o),
        .infinite_o(infinite_o), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i),
        .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o));
    fnu_dest_model peer (.result_i(result_o), .sign_i(sign_o),
        .underflow_i(underflow_o), .dest_word_o(dest_word));

    initial begin
        clk_sys_i = 1'b0;
        forever #10 clk_sys_i = ~clk_sys_i;
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic fnu_tb_exp_s expect_norm(input logic [59:0] o,
                                                input logic [14:0] ins);
        fnu_tb_exp_s e;
        logic [10:0] ex;
        logic [47:0] c;
        logic [5:0] n;
        logic [48:0] x;
        logic [11:0] d;
        logic [59:0] pos;
        logic sh, blk;
        ex = o[58:48] ^ {11{o[59]}};
        c = o[47:0] ^ {48{o[59]}};
        n = 6'h30;
        for (int b = 0; b < 48; b++) if (c[b]) n = 6'(47 - b);
        sh = ~&ex[9:0];
        if (!sh) n = 6'h00;
        x = {c, ins[9]} << n;
        d = {1'b0, ex} - {6'h00, n};
        blk = sh && ((n == 6'h30 && !ins[9]) || d[11]);
        pos = {1'b0, d[10:0], x[48:1]};
        e.r = blk ? '1 : ~pos;
        e.x = {12'h000, n};
        e.f = {blk, !sh && !ex[10], !sh && ex[10]};
        e.d = ins[8:3];
        e.s = o[59];
        e.w = blk ? 60'h0 : (o[59] ? ~pos : pos);
        return e;
    endfunction

    task check_val(input logic [147:0] got, exp, input string what);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // Request held until the edge that sees waitrequest low
    // Only the watchdog ends a wait that never sees the answer
    task bus(input logic wr, input logic [5:0] a, input logic [31:0] wd);
        @(posedge clk_sys_i);
        avs_address_i <= a;
        avs_writedata_i <= wd;
        avs_write_i <= wr;
        avs_read_i <= !wr;
        do begin
            @(posedge clk_sys_i);
        end while (avs_waitrequest_o !== 1'b0);
        rd = avs_readdata_o;
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
    endtask

    task issue(input logic [14:0] ins, input logic [59:0] o);
        fnu_tb_exp_s e;
        @(posedge clk_sys_i);
        issue_i <= 1'b1;
        instr_i <= ins;
        operand_i <= o;
        e = expect_norm(o, ins);
        if (en && ins[14:12] == NORM_F && ins[11:10] == NORM_M_HI) begin
            exp_q.push_back(e);
        end
    endtask

    task idle(input int n);
        @(posedge clk_sys_i);
        issue_i <= 1'b0;
        repeat (n) @(posedge clk_sys_i);
    endtask

    task stop_test();
        $display("checks %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    always @(posedge clk_sys_i) begin
        if (!reset_i && result_valid_o === 1'b1) begin
            if (exp_q.size() == 0) begin
                bad_count++;
                $display("MISMATCH %0t unexpected result", $time);
            end else begin
                check_val({result_o, index_o, underflow_o, indefinite_o,
                    infinite_o, result_dest_o, index_dest_o, sign_o,
                    dest_word}, exp_q.pop_front(), "result");
            end
        end
    end

    initial begin
        repeat (5000) @(posedge clk_sys_i);
        bad_count++;
        $display("MISMATCH %0t watchdog", $time);
        stop_test();
    end

    initial begin
        seed = 32'h00000012;
        en = 1'b1;
        bad_count = 0;
        comparisons = 0;
        reset_i = 1'b1;
        issue_i = 1'b0;
        instr_i = '0;
        operand_i = '0;
        avs_address_i = '0;
        avs_read_i = 1'b0;
        avs_write_i = 1'b0;
        avs_writedata_i = '0;
        repeat (8) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        bus(1'b0, REG_CTRL, 32'h0);
        check_val(148'(rd), 148'(CTRL_EN_RESET), "ctrl reset");
        bus(1'b1, 6'h3C, 32'hFFFFFFFF);
        bus(1'b0, 6'h3C, 32'h0);
        check_val(148'(rd), 148'h0, "unmapped read");
        $display("test registers done");
        // Special operands, both opcodes, back to back
        for (int i = 0; i < 14; i++) begin
            issue({NORM_F, NORM_M_HI, 1'(i % 2), 9'(rnd())}, corner[i / 2]);
        end
        idle(6);
        $display("test corners done");
        // Random counts, with stray opcodes that must be refused
        repeat (300) begin
            w = rnd();
            op = WORD_W'({rnd(), rnd()});
            op[47:0] = op[47:0] >> w[18:13];
            issue({w[2:0] == 3'h0 ? 3'h5 : NORM_F, NORM_M_HI, w[12:3]}, op);
        end
        idle(6);
        bus(1'b0, REG_INDEX, 32'h0);
        // Index reads zero once slots pass with no result
        check_val(148'(rd), 148'h0, "index register");
        bus(1'b0, REG_STATUS, 32'h0);
        check_val(148'(rd), 148'(32'h1 << ST_DONE), "status done");
        bus(1'b1, REG_STATUS, 32'h1 << ST_DONE);
        bus(1'b0, REG_STATUS, 32'h0);
        check_val(148'(rd), 148'h0, "status cleared");
        $display("test random done");
        // Disabled unit takes no issue
        bus(1'b1, REG_CTRL, 32'h0);
        en = 1'b0;
        issue({NORM_F, NORM_M_HI, 10'h000}, corner[5]);
        idle(6);
        bus(1'b1, REG_CTRL, 32'h1);
        en = 1'b1;
        $display("test disable done");
        stop_test();
    end
endmodule
